// ===== rtl/pei_pkg.sv
package pei_pkg;
  // power modes of the device, from highest to lowest consumption
  typedef enum logic [2:0] {
    PEI_RUN,
    PEI_SLEEP,
    PEI_LP_RUN,
    PEI_LP_SLEEP,
    PEI_STOP,
    PEI_OTHER
  } pei_mode_e;

  // source counts
  localparam int PEI_NUM_TIMERS = 3;
  localparam int PEI_NUM_COMP = 2;
  localparam int PEI_NUM_CLKSRC = 5;
  localparam int PEI_NUM_PINS = 8;
  // fixed pipeline depth of every path, in core_clk cycles
  localparam int PEI_PATH_LATENCY = 2;
  // timer index of the second general-purpose timer (rtc wakeup target)
  localparam int PEI_TIMER_B_IDX = 1;
  // select field reset value: selects source 0
  localparam logic [3:0] PEI_SEL_RESET = 4'h0;
  // timer trigger select layout: 0..2 timers, 3..4 comparators, 5 rtc wakeup (timer b only), 6..13 pins
  localparam logic [3:0] PEI_TSEL_TIMER = 4'h0;
  localparam logic [3:0] PEI_TSEL_COMP = 4'h3;
  localparam logic [3:0] PEI_TSEL_RTC = 4'h5;
  localparam logic [3:0] PEI_TSEL_PIN = 4'h6;
  // timer channel select layout: 0..1 comparators, 2..6 clock sources, 7..14 pins
  localparam logic [3:0] PEI_CSEL_COMP = 4'h0;
  localparam logic [3:0] PEI_CSEL_CLK = 4'h2;
  localparam logic [3:0] PEI_CSEL_PIN = 4'h7;
  // low power timer select layout: 0..1 comparators, 2 rtc event (trigger only, channel gets 0), 3..10 pins
  localparam logic [3:0] PEI_LSEL_COMP = 4'h0;
  localparam logic [3:0] PEI_LSEL_RTC = 4'h2;
  localparam logic [3:0] PEI_LSEL_PIN = 4'h3;
endpackage : pei_pkg

// ===== rtl/pei_stage.sv
`timescale 1ns/10ps
// fixed-depth delay line so every path has identical latency
module pei_stage #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 2
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] pipe [DEPTH];  // stage registers
  logic [WIDTH-1:0] next_pipe [DEPTH];  // next stage values

  // shift by one stage each cycle
  always_comb
  begin
    next_pipe[0] = din;
    for (int i = 1; i < DEPTH; i++)
    begin
      next_pipe[i] = pipe[i-1];
    end
  end

  // registers only
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < DEPTH; i++)
      begin
        pipe[i] <= '0;
      end
    end
    else
    begin
      pipe <= next_pipe;
    end
  end

  assign dout = pipe[DEPTH-1];
endmodule : pei_stage

// ===== rtl/pei_interconnect.sv
`timescale 1ns/10ps
module pei_interconnect #(
  parameter int NT = pei_pkg::PEI_NUM_TIMERS,
  parameter int NC = pei_pkg::PEI_NUM_COMP,
  parameter int NK = pei_pkg::PEI_NUM_CLKSRC,
  parameter int NP = pei_pkg::PEI_NUM_PINS
) (
  input wire logic core_clk,
  input wire logic rstn,
  // current power mode, from the power controller
  input wire pei_pkg::pei_mode_e power_mode,
  // sources
  input wire logic [NT-1:0] any_timer_trgo,
  input wire logic [NC-1:0] comparator_outputs,
  input wire logic rtc_wakeup,
  input wire logic rtc_event,
  input wire logic [NK-1:0] clock_sources,
  input wire logic [NP-1:0] pin_inputs,
  // static routing selects from each destination's configuration
  input wire logic [NT*4-1:0] timer_trig_sel,
  input wire logic [NT*4-1:0] timer_chan_sel,
  input wire logic [3:0] lp_timer_trig_sel,
  input wire logic [3:0] lp_timer_chan_sel,
  input wire logic [2:0] adc_trig_sel,
  // destinations
  output logic [NT-1:0] timer_trig_in,
  output logic [NT-1:0] timer_chan_in,
  output logic low_power_timer_trig,
  output logic low_power_timer_chan,
  output logic adc_conv_trig
);
  localparam int LAT = pei_pkg::PEI_PATH_LATENCY;
  localparam int NOUT = 2 * NT + 3;

  logic rst_meta;  // reset release synchroniser, first stage
  logic rst_n;  // synchronised reset used everywhere
  logic run_ok;  // mode allows run-through-low-power-sleep paths
  logic stop_ok;  // mode allows stop-capable paths
  logic [NOUT-1:0] routed;  // gated combinational selection
  logic [NOUT-1:0] delayed;  // output of fixed pipeline
  logic [NOUT-1:0] out_q;  // final registered outputs
  logic [NOUT-1:0] next_out_q;  // next output values

  // reset asserts at once, releases after two edges
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // pick one bit of a vector by select, out of range gives 0
  function automatic logic pick(input logic [31:0] vec, input int idx, input int n);
    logic r;
    r = 1'b0;
    if (idx >= 0 && idx < n)
    begin
      r = vec[idx];
    end
    return r;
  endfunction : pick

  // timer trigger source for timer t; a timer never triggers itself
  function automatic logic timer_trig_src(input int t, input logic [3:0] sel,
                                          input logic [NT-1:0] trg, input logic [NC-1:0] cmp,
                                          input logic rtc_w, input logic [NP-1:0] pin);
    logic r;
    r = 1'b0;
    if (sel < pei_pkg::PEI_TSEL_COMP)
    begin
      if (int'(sel) != t)
      begin
        r = pick(32'(trg), int'(sel), NT);
      end
    end
    else if (sel < pei_pkg::PEI_TSEL_RTC)
    begin
      r = pick(32'(cmp), int'(sel - pei_pkg::PEI_TSEL_COMP), NC);
    end
    else if (sel == pei_pkg::PEI_TSEL_RTC)
    begin
      // the wakeup event is wired only to timer b
      r = (t == pei_pkg::PEI_TIMER_B_IDX) ? rtc_w : 1'b0;
    end
    else
    begin
      r = pick(32'(pin), int'(sel - pei_pkg::PEI_TSEL_PIN), NP);
    end
    return r;
  endfunction : timer_trig_src

  // timer channel source
  function automatic logic timer_chan_src(input logic [3:0] sel, input logic [NC-1:0] cmp,
                                          input logic [NK-1:0] clk, input logic [NP-1:0] pin);
    logic r;
    r = 1'b0;
    if (sel < pei_pkg::PEI_CSEL_CLK)
    begin
      r = pick(32'(cmp), int'(sel - pei_pkg::PEI_CSEL_COMP), NC);
    end
    else if (sel < pei_pkg::PEI_CSEL_PIN)
    begin
      r = pick(32'(clk), int'(sel - pei_pkg::PEI_CSEL_CLK), NK);
    end
    else
    begin
      r = pick(32'(pin), int'(sel - pei_pkg::PEI_CSEL_PIN), NP);
    end
    return r;
  endfunction : timer_chan_src

  // low power timer source, shared by trigger and channel
  function automatic logic lp_src(input logic [3:0] sel, input logic [NC-1:0] cmp,
                                  input logic rtc_e, input logic [NP-1:0] pin, input logic trig);
    logic r;
    r = 1'b0;
    if (sel < pei_pkg::PEI_LSEL_RTC)
    begin
      r = pick(32'(cmp), int'(sel - pei_pkg::PEI_LSEL_COMP), NC);
    end
    else if (sel == pei_pkg::PEI_LSEL_RTC)
    begin
      r = trig ? rtc_e : 1'b0;
    end
    else
    begin
      r = pick(32'(pin), int'(sel - pei_pkg::PEI_LSEL_PIN), NP);
    end
    return r;
  endfunction : lp_src

  // mode gating: stop only keeps low power timer paths
  always_comb
  begin
    case (power_mode)
      pei_pkg::PEI_RUN, pei_pkg::PEI_SLEEP, pei_pkg::PEI_LP_RUN, pei_pkg::PEI_LP_SLEEP:
      begin
        run_ok = 1'b1;
        stop_ok = 1'b1;
      end
      pei_pkg::PEI_STOP:
      begin
        run_ok = 1'b0;
        stop_ok = 1'b1;
      end
      default:
      begin
        // any other mode, such as standby, kills every path
        run_ok = 1'b0;
        stop_ok = 1'b0;
      end
    endcase
  end

  // pure wiring selection; no bus access is on any path
  always_comb
  begin
    routed = '0;
    for (int t = 0; t < NT; t++)
    begin
      routed[t] = run_ok & timer_trig_src(t, timer_trig_sel[t*4 +: 4], any_timer_trgo,
                                          comparator_outputs, rtc_wakeup, pin_inputs);
      routed[NT+t] = run_ok & timer_chan_src(timer_chan_sel[t*4 +: 4], comparator_outputs,
                                             clock_sources, pin_inputs);
    end
    routed[2*NT] = stop_ok & lp_src(lp_timer_trig_sel, comparator_outputs, rtc_event,
                                    pin_inputs, 1'b1);
    routed[2*NT+1] = stop_ok & lp_src(lp_timer_chan_sel, comparator_outputs, rtc_event,
                                      pin_inputs, 1'b0);
    routed[2*NT+2] = run_ok & pick(32'(pin_inputs), int'(adc_trig_sel), NP);
  end

  // identical pipeline depth on all paths gives fixed latency
  pei_stage #(
    .WIDTH(NOUT),
    .DEPTH(LAT - 1)
  ) u_stage (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .din(routed),
    .dout(delayed)
  );

  // final stage also drops outputs the cycle mode leaves a path's set
  always_comb
  begin
    next_out_q = delayed;
    for (int t = 0; t < NT; t++)
    begin
      next_out_q[t] = delayed[t] & run_ok;
      next_out_q[NT+t] = delayed[NT+t] & run_ok;
    end
    next_out_q[2*NT] = delayed[2*NT] & stop_ok;
    next_out_q[2*NT+1] = delayed[2*NT+1] & stop_ok;
    next_out_q[2*NT+2] = delayed[2*NT+2] & run_ok;
  end

  // output registers only
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      out_q <= '0;
    end
    else
    begin
      out_q <= next_out_q;
    end
  end

  assign timer_trig_in = out_q[NT-1:0];
  assign timer_chan_in = out_q[2*NT-1:NT];
  assign low_power_timer_trig = out_q[2*NT];
  assign low_power_timer_chan = out_q[2*NT+1];
  assign adc_conv_trig = out_q[2*NT+2];

  // helper: mode history over the latency window; it resets to the dead mode so
  // the window only reads as stable once the pipeline holds post-reset samples
  pei_pkg::pei_mode_e mode_d1;  // mode one edge back
  pei_pkg::pei_mode_e mode_d2;  // mode two edges back
  logic mode_stable;  // same mode at this edge and the two before

  // registers only
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mode_d1 <= pei_pkg::PEI_OTHER;
      mode_d2 <= pei_pkg::PEI_OTHER;
    end
    else
    begin
      mode_d1 <= power_mode;
      mode_d2 <= mode_d1;
    end
  end

  assign mode_stable = (power_mode == mode_d1) && (power_mode == mode_d2);

  stop_gate_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (power_mode == pei_pkg::PEI_STOP) |=> (timer_trig_in == '0 && timer_chan_in == '0))
    else $error("timer path active in stop");
  adc_stop_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (power_mode == pei_pkg::PEI_STOP) |=> !adc_conv_trig)
    else $error("converter trigger active in stop");
  other_mode_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (power_mode == pei_pkg::PEI_OTHER) |=> (out_q == '0))
    else $error("path active in disallowed mode");
  lp_rtc_path_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (mode_stable && power_mode != pei_pkg::PEI_OTHER && lp_timer_trig_sel == pei_pkg::PEI_LSEL_RTC
     && $past(lp_timer_trig_sel, 2) == pei_pkg::PEI_LSEL_RTC)
    |-> low_power_timer_trig == $past(rtc_event, 2))
    else $error("rtc to low power timer latency wrong");
  rtc_wake_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (rst_n && rtc_wakeup && run_ok && timer_trig_sel[7:4] == pei_pkg::PEI_TSEL_RTC) ##1 run_ok
    |=> timer_trig_in[1])
    else $error("rtc wakeup not delivered to timer b");
  clk_chan_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (rst_n && clock_sources[0] && run_ok && timer_chan_sel[3:0] == pei_pkg::PEI_CSEL_CLK)
    ##1 run_ok
    |=> timer_chan_in[0])
    else $error("clock source not delivered to channel");
  trig_chain_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (rst_n && any_timer_trgo[0] && run_ok && timer_trig_sel[7:4] == 4'h0) ##1 run_ok
    |=> timer_trig_in[1])
    else $error("timer trigger latency wrong");
  comp_lp_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (rst_n && comparator_outputs[0] && stop_ok && lp_timer_chan_sel == pei_pkg::PEI_LSEL_COMP)
    ##1 stop_ok
    |=> low_power_timer_chan)
    else $error("comparator to low power timer missed");
  no_self_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (timer_trig_sel[3:0] == 4'h0 && $past(timer_trig_sel[3:0], 2) == 4'h0) |-> !timer_trig_in[0])
    else $error("timer triggered by itself");

  cov_stop_rtc_c: cover property (@(posedge core_clk) disable iff (!rst_n)
    power_mode == pei_pkg::PEI_STOP && low_power_timer_trig);
  cov_chain_c: cover property (@(posedge core_clk) disable iff (!rst_n) |timer_trig_in);
  cov_adc_c: cover property (@(posedge core_clk) disable iff (!rst_n) adc_conv_trig);
endmodule : pei_interconnect

// ===== testbench/pei_source_model.sv
`timescale 1ns/10ps
// far-side sources: comparators, timers, rtc, clock sources and pins
module pei_source_model (
  input wire logic core_clk,
  output logic [2:0] any_timer_trgo,
  output logic [1:0] comparator_outputs,
  output logic rtc_wakeup,
  output logic rtc_event,
  output logic [4:0] clock_sources,
  output logic [7:0] pin_inputs
);
  // new random levels each falling edge, so a stuck or stretched path shows
  initial
  begin
    {any_timer_trgo, comparator_outputs, rtc_wakeup, rtc_event} = 7'h00;
    {clock_sources, pin_inputs} = 13'h0000;
    forever
    begin
      @(negedge core_clk);
      {any_timer_trgo, comparator_outputs, rtc_wakeup, rtc_event} = 7'($urandom());
      {clock_sources, pin_inputs} = 13'($urandom());
    end
  end
endmodule : pei_source_model

// ===== testbench/peripheral_event_interconnect_bench.sv
`timescale 1ns/10ps
// random routing and power modes against a reference of the routing table
module peripheral_event_interconnect_bench;
  logic core_clk;
  logic rstn;
  pei_pkg::pei_mode_e power_mode;
  pei_pkg::pei_mode_e mode_q; // mode seen at the last edge
  logic [2:0] trgo;
  logic [1:0] cmp;
  logic rtc_w;
  logic rtc_e;
  logic [4:0] clks;
  logic [7:0] pins;
  logic [11:0] tsel;
  logic [11:0] csel;
  logic [3:0] lsel_t;
  logic [3:0] lsel_c;
  logic [2:0] asel;
  logic [8:0] dut_vec; // {adc, lp chan, lp trig, chan[2:0], trig[2:0]}
  logic [8:0] exp_d1;
  logic [8:0] exp_d2;
  logic in_rst;
  int stable; // edges since reset or last mode change
  int err_count;
  int checks_done;

  // clock, 10 ns period
  initial
  begin
    core_clk = 1'b0;
    forever
      #5 core_clk = ~core_clk;
  end

  pei_source_model u_src (.core_clk(core_clk), .any_timer_trgo(trgo),
    .comparator_outputs(cmp), .rtc_wakeup(rtc_w), .rtc_event(rtc_e),
    .clock_sources(clks), .pin_inputs(pins));

  pei_interconnect u_dut (.core_clk(core_clk), .rstn(rstn), .power_mode(power_mode),
    .any_timer_trgo(trgo), .comparator_outputs(cmp), .rtc_wakeup(rtc_w),
    .rtc_event(rtc_e), .clock_sources(clks), .pin_inputs(pins),
    .timer_trig_sel(tsel), .timer_chan_sel(csel), .lp_timer_trig_sel(lsel_t),
    .lp_timer_chan_sel(lsel_c), .adc_trig_sel(asel), .timer_trig_in(dut_vec[2:0]),
    .timer_chan_in(dut_vec[5:3]), .low_power_timer_trig(dut_vec[6]),
    .low_power_timer_chan(dut_vec[7]), .adc_conv_trig(dut_vec[8]));

  // reference: gated selected source for every destination
  function automatic logic [8:0] exp_vec();
    logic [8:0] r;
    logic [3:0] v;
    r = 9'h000;
    for (int t = 0; t < 3; t++)
    begin
      v = tsel[t*4+:4];
      if (v < 4'h3)
        r[t] = (int'(v) == t) ? 1'b0 : trgo[v[1:0]];
      else if (v < 4'h5)
        r[t] = cmp[v == 4'h4];
      else if (v == 4'h5)
        r[t] = (t == 1) ? rtc_w : 1'b0;
      else if (v < 4'he)
        r[t] = pins[3'(v - 4'h6)];
      v = csel[t*4+:4];
      if (v < 4'h2)
        r[t+3] = cmp[v[0]];
      else if (v < 4'h7)
        r[t+3] = clks[3'(v - 4'h2)];
      else if (v < 4'hf)
        r[t+3] = pins[3'(v - 4'h7)];
    end
    r[6] = (lsel_t < 4'h2) ? cmp[lsel_t[0]] : (lsel_t == 4'h2) ? rtc_e :
      (lsel_t < 4'hb) ? pins[3'(lsel_t - 4'h3)] : 1'b0;
    r[7] = (lsel_c < 4'h2) ? cmp[lsel_c[0]] :
      (lsel_c > 4'h2 && lsel_c < 4'hb) ? pins[3'(lsel_c - 4'h3)] : 1'b0;
    r[8] = pins[asel];
    // stop keeps only the low power timer paths, PEI_OTHER keeps none
    if (power_mode == pei_pkg::PEI_STOP || power_mode == pei_pkg::PEI_OTHER)
      r = r & 9'h0c0;
    if (power_mode == pei_pkg::PEI_OTHER)
      r = 9'h000;
    return r;
  endfunction : exp_vec

  task automatic check(input logic [8:0] seen, input logic [8:0] want, input string what);
    checks_done++;
    if (seen !== want)
    begin
      err_count++;
      $display("BAD %0t: %s seen %h want %h", $time, what, seen, want);
    end
  endtask : check

  task automatic print_verdict();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : print_verdict

  // reference pipeline, two edges deep like every path
  always @(posedge core_clk)
  begin
    exp_d2 <= exp_d1;
    exp_d1 <= exp_vec();
    mode_q <= power_mode;
    in_rst <= !rstn;
    stable <= (!rstn || power_mode != mode_q) ? 0 : stable + 1;
  end

  // compare only once gating at both stages has settled on one mode
  always @(negedge core_clk)
  begin
    if (!rstn && in_rst)
      check(dut_vec, 9'h000, "reset");
    else if (rstn && stable >= 6)
    begin
      check(dut_vec & 9'h007, exp_d2 & 9'h007, "timer trig");
      check(dut_vec & 9'h038, exp_d2 & 9'h038, "timer chan");
      check(dut_vec & 9'h0c0, exp_d2 & 9'h0c0, "lp timer");
      check(dut_vec & 9'h100, exp_d2 & 9'h100, "adc trig");
    end
  end

  // watchdog, about four times the expected run
  initial
  begin
    #60us;
    err_count++;
    print_verdict();
  end

  // main sequence: every mode in turn, selects random with corner codes
  initial
  begin
    power_mode = pei_pkg::PEI_RUN;
    {tsel, csel, lsel_t, lsel_c, asel} = 35'h0;
    rstn = 1'b0;
    err_count = 0;
    checks_done = 0;
    void'($urandom(27));
    repeat (12) @(negedge core_clk);
    rstn = 1'b1;
    for (int p = 0; p < 96; p++)
    begin
      @(negedge core_clk);
      power_mode = pei_pkg::pei_mode_e'(p % 6);
      tsel = 12'($urandom());
      csel = 12'($urandom());
      asel = 3'(p); // every pin onto the converter trigger
      lsel_t = 4'(p); // every low power timer code
      lsel_c = 4'(p + 7);
      if (p % 4 == 1)
        tsel[7:4] = 4'h5; // rtc wakeup onto timer b
      if (p % 4 == 2)
        tsel = 12'h210; // each timer on its own trigger
      if (p == 50)
      begin
        rstn = 1'b0; // reset again mid-run
        repeat (3) @(negedge core_clk);
        rstn = 1'b1;
      end
      repeat (15)
      begin
        @(negedge core_clk);
        if (p % 3 == 0 && $urandom_range(3) == 0)
          tsel = 12'($urandom()); // back-to-back select changes
      end
    end
    print_verdict();
  end
endmodule : peripheral_event_interconnect_bench
